//--- src/bbcfg_pkg.sv
// Billboard configuration constants shared by the device end and the controller end.
// Assumes one 100 MHz core clock on both ends.
package bbcfg_pkg;
	// EEPROM byte locations of billboard fields
	localparam logic [8:0] EE_SVID_LO = 9'h027;
	localparam logic [8:0] EE_SVID_HI = 9'h028;
	localparam logic [8:0] EE_PID_LO = 9'h029;
	localparam logic [8:0] EE_PID_HI = 9'h02A;
	localparam logic [8:0] EE_CFG = 9'h02B;
	localparam logic [8:0] EE_STR1_LEN = 9'h02C;
	localparam logic [8:0] EE_STR2_LEN = 9'h02D;
	localparam logic [8:0] EE_STR_BASE = 9'h100;
	localparam int STR_AREA_BYTES = 480;
	localparam logic [8:0] EE_LAST = EE_STR2_LEN;
	// Built-in defaults; identity values arbitrary
	localparam logic [15:0] DEF_SVID = 16'h1234;
	localparam logic [15:0] DEF_PID = 16'h5678;
	localparam logic [7:0] DEF_CFG = 8'h80;
	localparam logic [7:0] DEF_STR_LEN = 8'h00;
	// Port numbering of the hub
	localparam logic [2:0] NUM_EXT_PORTS = 3'h4;
	localparam logic [2:0] BB_PORT = 3'h5;
	// Exactly one alternate mode
	localparam logic [7:0] NUM_ALT_MODES = 8'h01;
	// Controller settle time between pin steps
	localparam int SETTLE_NS = 100;
	localparam int CLK_NS = 10;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage

//--- src/bbcfg_if.sv
// Pins between the power-delivery controller and the hub billboard logic.
// Plain point-to-point wires on one clock.
`timescale 1ns/1ps
interface bbcfg_if;
	logic billboard_present_en;
	logic [1:0] altmode_status_pins;
	modport device (input billboard_present_en, input altmode_status_pins);
	modport ctrl (output billboard_present_en, output altmode_status_pins);
endinterface

//--- src/bbcfg_ctrl.sv
// Controller end: drives enable and alt-mode status pins.
// Assumes user requests are on the same clock.
`timescale 1ns/1ps
module bbcfg_ctrl
	import bbcfg_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// User side
	input wire logic i_want_en,
	input wire logic [1:0] i_status,
	input wire logic i_single_gpio,
	input wire logic i_alt_fail,
	output logic o_busy,
	// Pins
	bbcfg_if.ctrl pins
);
	typedef enum logic [1:0] {
		BBC_IDLE = 2'b00,
		BBC_DROP = 2'b01,
		BBC_SET = 2'b10,
		BBC_RAISE = 2'b11
	} bbc_state_t;
	bbc_state_t state;
	logic [7:0] cnt;
	logic en_q;
	logic [1:0] st_q;
	logic want;
	logic [1:0] tgt;
	always_comb begin
		want = i_single_gpio ? i_alt_fail : i_want_en;
		tgt = i_single_gpio ? 2'b00 : i_status; // RULE8
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state <= BBC_IDLE;
			cnt <= 8'h00;
			en_q <= 1'b0;
			st_q <= 2'b00;
		end else begin
			case (state)
				BBC_IDLE: begin
					if (want && en_q && st_q != tgt) begin
						en_q <= 1'b0; // RULE7
						state <= BBC_DROP;
						cnt <= 8'(SETTLE_CYC);
					end else if (want && !en_q) begin
						st_q <= tgt; // RULE6
						state <= BBC_RAISE;
						cnt <= 8'(SETTLE_CYC);
					end else if (!want) begin
						en_q <= 1'b0;
					end
				end
				BBC_DROP: begin
					if (cnt == 8'h00) begin
						st_q <= tgt; // RULE7
						state <= BBC_SET;
						cnt <= 8'(SETTLE_CYC);
					end else cnt <= cnt - 8'h01;
				end
				BBC_SET, BBC_RAISE: begin
					if (cnt == 8'h00) begin
						en_q <= want; // RULE6
						state <= BBC_IDLE;
					end else cnt <= cnt - 8'h01;
				end
				default: state <= BBC_IDLE;
			endcase
		end
	end
	assign pins.billboard_present_en = en_q;
	assign pins.altmode_status_pins = st_q;
	assign o_busy = (state != BBC_IDLE);
endmodule // bbcfg_ctrl

//--- src/bbcfg_dev.sv
// Device end: billboard attach control and EEPROM descriptor loader.
// Assumes an EEPROM byte reader on the same clock, answer one or more cycles later.
`timescale 1ns/1ps
// Operation
// [RULE1] Billboard sits on highest downstream port
// [RULE2] Advertise exactly one alternate mode
// [RULE3] Pins in EEPROM mode, registers in SMBus
// [RULE4] Present billboard while enable is high
// [RULE5] Status pins copied into bmConfigured field
// [RULE6] Controller sets status before raising enable
// [RULE7] Status change: drop enable, update, raise
// [RULE8] Single GPIO: tie status low, enable
// [RULE9] Load billboard fields from EEPROM at power-up
// [RULE10] No EEPROM: use built-in defaults
// [RULE11] Load SVID and PID; reuse hub VID
// [RULE12] Configuration byte defaults to 0x80
// [RULE13] String lengths in characters; zero means ROM
// [RULE14] Strings share 480 bytes, string 2 aligned
// [RULE15] String 1 URL mandatory, string 2 optional
// [RULE16] Sample serial mode pin at reset release
// [RULE17] Sync pins, latch on rise, detach on fall
module bbcfg_dev
	import bbcfg_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Strap and EEPROM presence
	input wire logic i_serial_mode_select,
	input wire logic i_eeprom_present,
	// SMBus-mode register controls
	input wire logic i_reg_present_en,
	input wire logic [1:0] i_reg_altmode_status,
	// EEPROM byte reader
	output logic o_ee_rd,
	output logic [8:0] o_ee_addr,
	input wire logic i_ee_valid,
	input wire logic [7:0] i_ee_data,
	// Hub vendor ID
	input wire logic [15:0] i_hub_vid,
	// Descriptor outputs
	output logic o_load_done,
	output logic o_eeprom_mode,
	output logic o_bb_attached,
	output logic o_bb_detach,
	output logic [2:0] o_bb_port,
	output logic [1:0] o_bm_configured,
	output logic [7:0] o_num_alt_modes,
	output logic [15:0] o_vid,
	output logic [15:0] o_svid,
	output logic [15:0] o_pid,
	output logic [7:0] o_cfg,
	output logic [7:0] o_url_string_len,
	output logic [7:0] o_altmode_string_len,
	output logic o_url_from_rom,
	output logic o_altmode_from_rom,
	output logic o_altmode_present,
	output logic [9:0] o_str2_addr,
	output logic o_str_len_error,
	// Device pins
	bbcfg_if.device pins
);
	typedef enum logic [1:0] {
		BBD_STRAP = 2'b00,
		BBD_READ = 2'b01,
		BBD_WAIT = 2'b10,
		BBD_DONE = 2'b11
	} bbd_state_t;
	bbd_state_t state;
	logic [2:0] en_sync;
	logic [1:0] st_s1;
	logic [1:0] st_s2;
	logic [1:0] mode_sync;
	logic [1:0] eep_sync;
	logic en_now;
	logic en_prev;
	logic [1:0] st_now;
	logic [10:0] s1_bytes;
	logic [10:0] s2_start;
	logic [10:0] s2_bytes;

	// Two-stage synchronisers
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			en_sync <= 3'h0;
			st_s1 <= 2'h0;
			st_s2 <= 2'h0;
		end else begin
			en_sync <= {en_sync[1:0], pins.billboard_present_en}; // RULE17
			st_s1 <= pins.altmode_status_pins;
			st_s2 <= st_s1; // RULE17
		end
	end

	// Strap synchronisers run through reset so the level is settled at release
	always_ff @(posedge i_clk_sys) begin
		mode_sync <= {mode_sync[0], i_serial_mode_select}; // RULE16
		eep_sync <= {eep_sync[0], i_eeprom_present};
	end

	// Mode latched at first edge after release; pin low selects SMBus
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) o_eeprom_mode <= 1'b0;
		else if (state == BBD_STRAP) o_eeprom_mode <= mode_sync[1]; // RULE16
	end

	// SMBus mode takes same-clock register controls, no synchroniser
	always_comb begin
		en_now = o_eeprom_mode ? en_sync[1] : i_reg_present_en; // RULE3
		st_now = o_eeprom_mode ? st_s2 : i_reg_altmode_status; // RULE3
		en_prev = o_eeprom_mode ? en_sync[2] : o_bb_attached;
	end

	// Attach and status latch
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_bb_attached <= 1'b0;
			o_bb_detach <= 1'b0;
			o_bm_configured <= 2'b00;
		end else begin
			o_bb_detach <= 1'b0;
			// Status taken once per attach; later moves wait for a re-raise
			if (o_load_done && en_now && !o_bb_attached) begin
				o_bb_attached <= 1'b1; // RULE4
				o_bm_configured <= st_now; // RULE5 RULE17
			end else if (!en_now && o_bb_attached) begin
				o_bb_attached <= 1'b0; // RULE4
				// Pulse only when enable was high the cycle before
				o_bb_detach <= en_prev; // RULE17
			end
		end
	end

	// EEPROM read sequencer
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state <= BBD_STRAP;
			o_ee_rd <= 1'b0;
			o_ee_addr <= EE_SVID_LO;
			o_load_done <= 1'b0;
		end else begin
			o_ee_rd <= 1'b0;
			case (state)
				BBD_STRAP: begin
					if (mode_sync[1] && eep_sync[1]) state <= BBD_READ; // RULE9
					else begin
						state <= BBD_DONE; // RULE10
						o_load_done <= 1'b1;
					end
				end
				BBD_READ: begin
					o_ee_rd <= 1'b1;
					state <= BBD_WAIT;
				end
				BBD_WAIT: begin
					if (i_ee_valid) begin
						if (o_ee_addr == EE_LAST) begin
							state <= BBD_DONE;
							o_load_done <= 1'b1;
						end else begin
							o_ee_addr <= o_ee_addr + 9'h001;
							state <= BBD_READ;
						end
					end
				end
				BBD_DONE: ;
				default: state <= BBD_STRAP;
			endcase
		end
	end

	// Descriptor fields: defaults until an EEPROM byte replaces them
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_svid <= DEF_SVID; // RULE10
			o_pid <= DEF_PID;
			o_cfg <= DEF_CFG; // RULE12
			o_url_string_len <= DEF_STR_LEN;
			o_altmode_string_len <= DEF_STR_LEN;
		end else if (state == BBD_WAIT && i_ee_valid) begin
			case (o_ee_addr)
				EE_SVID_LO: o_svid[7:0] <= i_ee_data; // RULE11
				EE_SVID_HI: o_svid[15:8] <= i_ee_data; // RULE11
				EE_PID_LO: o_pid[7:0] <= i_ee_data; // RULE11
				EE_PID_HI: o_pid[15:8] <= i_ee_data; // RULE11
				EE_CFG: o_cfg <= i_ee_data; // RULE12
				EE_STR1_LEN: o_url_string_len <= i_ee_data; // RULE13
				EE_STR2_LEN: o_altmode_string_len <= i_ee_data; // RULE13
				default: ;
			endcase
		end
	end

	// String layout: lengths count 2-byte characters
	always_comb begin
		s1_bytes = {2'b00, o_url_string_len, 1'b0}; // RULE13
		s2_start = (s1_bytes + 11'd3) & 11'h7FC; // RULE14
		s2_bytes = {2'b00, o_altmode_string_len, 1'b0};
	end
	assign o_str2_addr = {1'b0, EE_STR_BASE} + s2_start[9:0]; // RULE14
	assign o_str_len_error = (s2_start + s2_bytes) > 11'(STR_AREA_BYTES); // RULE14
	assign o_url_from_rom = (o_url_string_len == 8'h00); // RULE13 RULE15
	assign o_altmode_from_rom = (o_altmode_string_len == 8'h00); // RULE13
	assign o_altmode_present = 1'b1; // RULE15
	// Fixed descriptor facts
	assign o_bb_port = BB_PORT; // RULE1
	assign o_num_alt_modes = NUM_ALT_MODES; // RULE2
	assign o_vid = i_hub_vid; // RULE11
endmodule // bbcfg_dev

//--- testbench/bbcfg_assertions.sv
// Checker: billboard pin link and device attach outputs.
// Instantiated beside the interface that joins the two ends.
`timescale 1ns/1ps
module bbcfg_assertions (
	// Clock, reset, pins, device outputs
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic billboard_present_en,
	input wire logic [1:0] altmode_status_pins,
	input wire logic o_eeprom_mode,
	input wire logic o_bb_attached,
	input wire logic o_bb_detach,
	input wire logic [1:0] o_bm_configured
);
	default clocking dc @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	chk_status_setup: assert property ($rose(billboard_present_en) |-> $past(altmode_status_pins, 10) == altmode_status_pins)
		else $error("status moved inside setup");
	chk_status_hold: assert property (billboard_present_en && $past(billboard_present_en) |-> $stable(altmode_status_pins))
		else $error("status moved while enabled");
	chk_attach_delay: assert property (o_eeprom_mode && $rose(billboard_present_en) |-> ##[1:3] o_bb_attached)
		else $error("attach late");
	chk_detach_pulse: assert property ($fell(billboard_present_en) && o_bb_attached |-> ##[1:3] o_bb_detach)
		else $error("detach missing");
	chk_detach_single: assert property (o_bb_detach |=> !o_bb_detach)
		else $error("detach too long");
	chk_detach_drop: assert property (o_bb_detach |-> !o_bb_attached)
		else $error("attached during detach");
	chk_bm_copy: assert property (o_eeprom_mode && $rose(o_bb_attached) |-> o_bm_configured == altmode_status_pins)
		else $error("bm not copied");
	chk_off_hidden: assert property ((o_eeprom_mode && !billboard_present_en) [*4] |-> !o_bb_attached)
		else $error("attached while disabled");
	cover property ($rose(o_bb_attached));
	cover property (o_bb_detach);
	cover property ($rose(billboard_present_en) && altmode_status_pins == 2'h3);
endmodule // bbcfg_assertions

//--- testbench/testbench.sv
// Testbench: controller and device joined by the pin interface.
// Models the EEPROM byte reader; one clock, async reset.
`timescale 1ns/1ps
module testbench;
	import bbcfg_pkg::*;
	logic i_clk_sys, i_rst, want, single, fail, strap, eep, reg_en, ee_valid, busy;
	logic ee_rd, load_done, eep_mode, att, det, url_rom, alt_rom, alt_pres, len_err;
	logic [1:0] status, reg_st, bm;
	logic [7:0] ee_data, nalt, cfg, len1, len2;
	logic [7:0] ee_rom [0:6] = '{8'h01, 8'hAB, 8'h02, 8'hCD, 8'h80, 8'h03, 8'h05};
	logic [3:0] rows [4] = '{4'h0, 4'hF, 4'h5, 4'hA};
	logic [8:0] ee_addr;
	logic [9:0] str2;
	logic [2:0] port;
	logic [15:0] vid, svid, pid;
	int fail_count = 0, check_count = 0, n;
	`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
	`define WAITF(c) begin for (n = 0; n < 100; n++) begin @(negedge i_clk_sys); if (c) break; end \
		if (n == 100) begin fail_count++; tally_and_finish(); end end
	bbcfg_if pins_if ();
	bbcfg_ctrl bbcfg_ctrl_inst (.i_clk_sys, .i_rst, .i_want_en(want), .i_status(status), .i_single_gpio(single),
		.i_alt_fail(fail), .o_busy(busy), .pins(pins_if.ctrl));
	bbcfg_dev bbcfg_dev_inst (.i_clk_sys, .i_rst, .i_serial_mode_select(strap), .i_eeprom_present(eep),
		.i_reg_present_en(reg_en), .i_reg_altmode_status(reg_st), .o_ee_rd(ee_rd), .o_ee_addr(ee_addr),
		.i_ee_valid(ee_valid), .i_ee_data(ee_data), .i_hub_vid(16'hBEEF), .o_load_done(load_done),
		.o_eeprom_mode(eep_mode), .o_bb_attached(att), .o_bb_detach(det), .o_bb_port(port),
		.o_bm_configured(bm), .o_num_alt_modes(nalt), .o_vid(vid), .o_svid(svid), .o_pid(pid), .o_cfg(cfg),
		.o_url_string_len(len1), .o_altmode_string_len(len2), .o_url_from_rom(url_rom),
		.o_altmode_from_rom(alt_rom), .o_altmode_present(alt_pres), .o_str2_addr(str2),
		.o_str_len_error(len_err), .pins(pins_if.device));
	bbcfg_assertions bbcfg_assertions_inst (.i_clk_sys, .i_rst,
		.billboard_present_en(pins_if.billboard_present_en), .altmode_status_pins(pins_if.altmode_status_pins),
		.o_eeprom_mode(eep_mode), .o_bb_attached(att), .o_bb_detach(det), .o_bm_configured(bm));
	// EEPROM answers one cycle after each read pulse
	always @(posedge i_clk_sys) begin
		ee_valid <= ee_rd;
		ee_data <= ee_rom[ee_addr - 9'h027];
	end
	initial begin
		i_clk_sys = 0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	task automatic rst_dut(input logic s, input logic e);
		@(posedge i_clk_sys);
		strap <= s;
		eep <= e;
		i_rst <= 1;
		repeat (5) @(posedge i_clk_sys);
		i_rst <= 0;
		@(negedge i_clk_sys);
	endtask
	task automatic show(input logic [1:0] st);
		@(posedge i_clk_sys);
		status <= st;
		want <= 1;
		`WAITF(att)
	endtask
	task automatic hide;
		@(posedge i_clk_sys);
		want <= 0;
		`WAITF(det)
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		{want, single, fail, reg_en, status, reg_st} = '0;
		i_rst = 1;
		rst_dut(1, 0);
		`CHK({svid, pid, len1, len2}, {DEF_SVID, DEF_PID, 16'h0})
		`CHK(cfg, 8'h80)
		`CHK({url_rom, alt_rom}, 2'b11)
		`CHK({port, nalt}, {BB_PORT, NUM_ALT_MODES})
		`CHK(vid, 16'hBEEF)
		$display("test defaults done");
		for (int i = 0; i < 4; i++) begin
			show(rows[i][3:2]);
			`CHK(bm, rows[i][1:0])
			hide();
			`CHK({att, busy}, 2'b00)
		end
		$display("test rows done");
		show(2'h1);
		@(posedge i_clk_sys) status <= 2'h2;
		`WAITF(det)
		`CHK(busy, 1'b1)
		`WAITF(att)
		`CHK(bm, 2'h2)
		hide();
		$display("test status change done");
		@(posedge i_clk_sys) single <= 1;
		repeat (SETTLE_CYC + 2) @(posedge i_clk_sys);
		fail <= 1;
		`WAITF(att)
		`CHK({bm, pins_if.altmode_status_pins}, 4'h0)
		@(posedge i_clk_sys) fail <= 0;
		`WAITF(det)
		@(posedge i_clk_sys) single <= 0;
		$display("test single output done");
		rst_dut(1, 1);
		`WAITF(load_done)
		`CHK({svid, pid, cfg}, 40'hAB01CD0280)
		`CHK({len1, len2, url_rom, alt_rom, alt_pres}, {16'h0305, 3'b001})
		`CHK({str2, len_err}, {10'h108, 1'b0})
		$display("test eeprom done");
		ee_rom[5] = 8'hEF;
		ee_rom[6] = 8'h01;
		rst_dut(1, 1);
		`WAITF(load_done)
		`CHK({str2, len_err}, {10'h2E0, 1'b1})
		$display("test string overflow done");
		rst_dut(0, 0);
		@(posedge i_clk_sys) begin
			reg_st <= 2'h2;
			reg_en <= 1;
		end
		`WAITF(att)
		`CHK({eep_mode, bm}, 3'b010)
		@(posedge i_clk_sys) reg_en <= 0;
		`WAITF(!att)
		@(posedge i_clk_sys) want <= 1;
		repeat (20) @(negedge i_clk_sys);
		`CHK(att, 1'b0)
		@(posedge i_clk_sys) want <= 0;
		$display("test register mode done");
		tally_and_finish();
	end
endmodule // testbench
